//--- rtl/touch_point_pkg.sv
package touch_point_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [11:0] SAMPLING_CONTROL_OFFSET = 12'h104;
  localparam logic [11:0] DETECTION_MODE_OFFSET   = 12'h108;
  localparam logic [11:0] SECOND_POINT_OFFSET     = 12'h11c;
  localparam logic [11:0] FIRST_POINT_OFFSET      = 12'h124;
  localparam logic [11:0] THIRD_POINT_OFFSET      = 12'h18c;
  localparam logic [11:0] FOURTH_POINT_OFFSET     = 12'h190;
  localparam int          ADDR_WIDTH              = 12;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int          SAMPLING_MODE_WIDTH = 2;
  localparam logic [1:0]  SAMPLING_MODE_RESET = 2'h3;
  localparam logic [1:0]  SAMPLING_MODE_OFF   = 2'h0;
  localparam logic [1:0]  SAMPLING_MODE_ON    = 2'h3;
  localparam logic [0:0]  DETECTION_RESET     = 1'h1;
  localparam logic [0:0]  DETECTION_EXTENDED  = 1'h0;
  localparam logic [0:0]  DETECTION_COMPAT    = 1'h1;
  localparam int          COORD_X_LSB         = 16;
  localparam int          COORD_WIDTH         = 16;
  localparam logic [15:0] NO_TOUCH_COORD      = 16'h8000;
  localparam logic [31:0] POINT_RESET         = 32'h80008000;
  localparam int          POINT_COUNT         = 4;
  localparam int          POINT_INDEX_WIDTH   = 2;

  // ---------------------------------------------------------------------------
  // Latch state of the point update path
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    UPD_IDLE    = 3'b001,
    UPD_CAPTURE = 3'b010,
    UPD_COMMIT  = 3'b100
  } update_state_type;

endpackage : touch_point_pkg

//--- rtl/point_store.sv
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------------------
// Four-word store of calibrated touch points with registered read data
// -----------------------------------------------------------------------------
module point_store
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_index,
  input  wire logic [31:0] wr_data,
  input  wire logic [1:0]  rd_index,
  output logic      [31:0] rd_data
);

  logic [31:0] word_q [4];

  // Each word resets to the no-touch pattern and is overwritten on a write.
  generate
    for (genvar i = 0; i < touch_point_pkg::POINT_COUNT; i++)
    begin : g_word
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          word_q[i] <= touch_point_pkg::POINT_RESET;
        else if (wr_en && (wr_index == 2'(i)))
          word_q[i] <= wr_data;
      end
    end
  endgenerate

  // Read data come from a register, so a read sees the word one edge later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_data <= touch_point_pkg::POINT_RESET;
    else
      rd_data <= word_q[rd_index];
  end

endmodule : point_store

`default_nettype wire

//--- rtl/capacitive_touch_point_regs.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - Two-bit sampling mode, 00 off, 11 on
// - Detection select: 0 extended, 1 compatibility
// - First point: X high, Y low, read-only
// - First point updated in both modes
// - Second point register, read-only, no-touch reset
// - Third point register, read-only, no-touch reset
// - Fourth point register, read-only, no-touch reset
// - Points two to four meaningful only extended
// - Compatibility mode after reset
// - Same calibration in both modes
module capacitive_touch_point_regs
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        point_valid,
  input  wire logic [1:0]  point_index,
  input  wire logic        point_present,
  input  wire logic [15:0] point_x,
  input  wire logic [15:0] point_y,
  output logic             sampling_enable,
  output logic             extended_mode
);

  // ---------------------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------------------

  // Maps an offset to a point slot; used only for the store read index.
  function automatic logic [1:0] point_slot(input logic [11:0] addr);
    case (addr)
      touch_point_pkg::FIRST_POINT_OFFSET:  point_slot = 2'h0;
      touch_point_pkg::SECOND_POINT_OFFSET: point_slot = 2'h1;
      touch_point_pkg::THIRD_POINT_OFFSET:  point_slot = 2'h2;
      default:                              point_slot = 2'h3;
    endcase
  endfunction : point_slot

  // True for any of the four point registers.
  function automatic logic is_point(input logic [11:0] addr);
    is_point = (addr == touch_point_pkg::FIRST_POINT_OFFSET) ||
               (addr == touch_point_pkg::SECOND_POINT_OFFSET) ||
               (addr == touch_point_pkg::THIRD_POINT_OFFSET) ||
               (addr == touch_point_pkg::FOURTH_POINT_OFFSET);
  endfunction : is_point

  // True for the two writable control registers.
  function automatic logic is_control(input logic [11:0] addr);
    is_control = (addr == touch_point_pkg::SAMPLING_CONTROL_OFFSET) ||
                 (addr == touch_point_pkg::DETECTION_MODE_OFFSET);
  endfunction : is_control

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [1:0]  sampling_mode_q;
  logic [0:0]  detection_q;
  logic        setup;
  logic        access_q;
  logic        wr_take;

  // The setup cycle is seen with penable low; the slave answers two edges
  // later, so the point store has registered the addressed word by then.
  assign setup   = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite;

  // Host writes to the sampling mode field; undefined codes are stored as
  // written but only 11 lets samples through.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sampling_mode_q <= touch_point_pkg::SAMPLING_MODE_RESET;
    else if (wr_take && (paddr == touch_point_pkg::SAMPLING_CONTROL_OFFSET))
      sampling_mode_q <= pwdata[1:0];
  end

  // Detection selector comes up in compatibility mode.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      detection_q <= touch_point_pkg::DETECTION_RESET;
    else if (wr_take && (paddr == touch_point_pkg::DETECTION_MODE_OFFSET))
      detection_q <= pwdata[0:0];
  end

  // Mode outputs to the touch engine, registered.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sampling_enable <= 1'b1;
      extended_mode   <= 1'b0;
    end
    else
    begin
      sampling_enable <= (sampling_mode_q == touch_point_pkg::SAMPLING_MODE_ON);
      extended_mode   <= (detection_q == touch_point_pkg::DETECTION_EXTENDED);
    end
  end

  // ---------------------------------------------------------------------------
  // Point update path
  // ---------------------------------------------------------------------------
  touch_point_pkg::update_state_type upd_state_q;
  logic [1:0]  cap_index_q;
  logic [31:0] cap_word_q;
  logic        store_wr;
  logic        accept;

  // Calibration is done upstream and identical for both modes, so a point
  // arrives here already in screen coordinates and is stored as is. In
  // compatibility mode only slot zero is accepted, keeping the other slots
  // at the no-touch pattern. Sampling off blocks every new sample.
  assign accept = point_valid && sampling_enable &&
                  (extended_mode || (point_index == 2'h0));

  // Three-step latch: capture the sample, then commit it to the store.
  // Every accepted sample moves the latch into capture, whatever the state,
  // because the capture register below is reloaded on each accept. Staying
  // in capture on back-to-back samples writes each one in the following
  // cycle, so a sample offered every cycle is never dropped. The commit
  // state is a one-cycle tail after the last write before going idle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      upd_state_q <= touch_point_pkg::UPD_IDLE;
    else
    begin
      case (upd_state_q)
        touch_point_pkg::UPD_IDLE:
        begin
          if (accept)
            upd_state_q <= touch_point_pkg::UPD_CAPTURE;
        end
        touch_point_pkg::UPD_CAPTURE:
        begin
          if (accept)
            upd_state_q <= touch_point_pkg::UPD_CAPTURE;
          else
            upd_state_q <= touch_point_pkg::UPD_COMMIT;
        end
        touch_point_pkg::UPD_COMMIT:
        begin
          if (accept)
            upd_state_q <= touch_point_pkg::UPD_CAPTURE;
          else
            upd_state_q <= touch_point_pkg::UPD_IDLE;
        end
        default:
        begin
          upd_state_q <= touch_point_pkg::UPD_IDLE;
        end
      endcase
    end
  end

  // The sample is packed X high, Y low; an absent touch becomes 0x8000 in
  // both halves so software sees the same pattern as after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_index_q <= 2'h0;
      cap_word_q  <= touch_point_pkg::POINT_RESET;
    end
    else if (accept)
    begin
      cap_index_q <= point_index;
      if (point_present)
        cap_word_q <= {point_x, point_y};
      else
        cap_word_q <= {touch_point_pkg::NO_TOUCH_COORD,
                       touch_point_pkg::NO_TOUCH_COORD};
    end
  end

  assign store_wr = (upd_state_q == touch_point_pkg::UPD_CAPTURE);

  // Leaving extended mode clears slots one to three back to no-touch, one
  // slot per cycle, so stale multi-touch data do not linger.
  logic [1:0] clear_idx_q;
  logic       clearing_q;
  logic       mode_was_ext_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_was_ext_q <= 1'b0;
      clearing_q     <= 1'b0;
      clear_idx_q    <= 2'h1;
    end
    else
    begin
      mode_was_ext_q <= extended_mode;
      if (mode_was_ext_q && !extended_mode)
      begin
        clearing_q  <= 1'b1;
        clear_idx_q <= 2'h1;
      end
      else if (clearing_q && !store_wr)
      begin
        clear_idx_q <= clear_idx_q + 2'h1;
        if (clear_idx_q == 2'h3)
          clearing_q <= 1'b0;
      end
    end
  end

  logic        mem_wr;
  logic [1:0]  mem_idx;
  logic [31:0] mem_data;
  logic [31:0] mem_rd;

  // Live samples have priority over the clearing walk: a clear step that
  // meets a store write waits one cycle instead of overwriting fresh data.
  // Software that leaves extended mode should allow a few cycles before it
  // trusts slots one to three to show the no-touch pattern.
  always_comb
  begin
    mem_wr   = 1'b0;
    mem_idx  = clear_idx_q;
    mem_data = touch_point_pkg::POINT_RESET;
    if (store_wr)
    begin
      mem_wr   = 1'b1;
      mem_idx  = cap_index_q;
      mem_data = cap_word_q;
    end
    else if (clearing_q)
    begin
      mem_wr   = 1'b1;
    end
  end

  point_store u_store
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (mem_wr),
    .wr_index (mem_idx),
    .wr_data  (mem_data),
    .rd_index (point_slot(paddr)),
    .rd_data  (mem_rd)
  );

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------

  // The point store only sees a new address at the setup edge, and its read
  // word comes out of a register, so the word is ready one edge later. One
  // wait state is therefore inserted in every transfer:
  //   setup edge    : store and control word are addressed, access_q rises.
  //   next edge     : pslverr, pready and, on a read, prdata are loaded, access_q falls.
  //   third edge    : the master samples pready high; a write lands here.
  // The extra cycle costs bus time, but keeps every output a plain flop and
  // the store free of a combinational read path.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      access_q <= 1'b0;
    else
      access_q <= setup;
  end

  // pready is a one-cycle pulse; the master holds the request until it sees it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= access_q;
  end

  // Unmapped addresses answer with an error; writes to the point registers
  // are ignored, since they are read-only, but answer without error. The
  // address still stands in the first access cycle, so it is decoded there.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= access_q && !is_point(paddr) && !is_control(paddr);
  end

  // Control reads are captured at the setup edge. A write to a control field
  // only lands at the end of an earlier transfer, so the captured word is
  // never older than the last completed write.
  logic [31:0] ctrl_rd_q;
  logic        point_rd_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_rd_q  <= 32'h0;
      point_rd_q <= 1'b0;
    end
    else if (setup)
    begin
      point_rd_q <= is_point(paddr);
      if (paddr == touch_point_pkg::SAMPLING_CONTROL_OFFSET)
        ctrl_rd_q <= {30'h0, sampling_mode_q};
      else if (paddr == touch_point_pkg::DETECTION_MODE_OFFSET)
        ctrl_rd_q <= {31'h0, detection_q};
      else
        ctrl_rd_q <= 32'h0;
    end
  end

  // prdata is a flop of its own, loaded in the first access cycle from the
  // store register, which was addressed at the setup edge, or from the
  // control word captured there. Unmapped reads return zero, and prdata
  // keeps its value until the next read so an idle bus shows no glitches.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (access_q && !pwrite)
    begin
      if (point_rd_q)
        prdata <= mem_rd;
      else
        prdata <= ctrl_rd_q;
    end
  end

endmodule : capacitive_touch_point_regs

`default_nettype wire

//--- tb/touch_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Port checker for the touch point register block
// ----------------------------------------------------------------------------
module touch_regs_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sampling_enable,
  input wire logic        extended_mode
);
  // Decoded completed accesses; the mode outputs trail their register by one cycle.
  wire acc    = psel & penable & pready;
  wire is_smp = paddr == 12'h104;
  wire is_det = paddr == 12'h108;
  wire mapped = is_smp | is_det | paddr == 12'h11c | paddr == 12'h124 |
                paddr == 12'h18c | paddr == 12'h190;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_answer; psel && !penable |-> ##2 pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer held too long");
  property p_quiet; !psel |=> !pready; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_boot; $rose(presetn) |-> sampling_enable && !extended_mode; endproperty
  a_boot: assert property (p_boot) else $error("modes wrong after reset");
  property p_smp_wr;
    acc && pwrite && is_smp |-> ##2 sampling_enable == ($past(pwdata[1:0], 2) == 2'h3);
  endproperty
  a_smp_wr: assert property (p_smp_wr) else $error("sampling not set");
  property p_det_wr;
    acc && pwrite && is_det |-> ##2 extended_mode == ($past(pwdata[0], 2) == 1'b0);
  endproperty
  a_det_wr: assert property (p_det_wr) else $error("detection not set");
  property p_smp_rd;
    acc && !pwrite && is_smp |-> prdata[31:2] == 30'h0 && (prdata[1:0] == 2'h3) == sampling_enable;
  endproperty
  a_smp_rd: assert property (p_smp_rd) else $error("sampling read wrong");
  property p_det_rd;
    acc && !pwrite && is_det |-> prdata[31:1] == 31'h0 && !prdata[0] == extended_mode;
  endproperty
  a_det_rd: assert property (p_det_rd) else $error("detection read wrong");
endmodule : touch_regs_checker

bind capacitive_touch_point_regs touch_regs_checker checker_inst
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .sampling_enable, .extended_mode
);

`default_nettype wire

//--- tb/touch_panel_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Panel side: offers one calibrated sample per call
// ----------------------------------------------------------------------------
module touch_panel_model
(
  input  wire logic        pclk,
  output logic             point_valid,
  output logic      [1:0]  point_index,
  output logic             point_present,
  output logic      [15:0] point_x,
  output logic      [15:0] point_y
);
  initial
  begin
    point_valid   = 1'b0;
    point_index   = 2'h0;
    point_present = 1'b0;
    point_x       = 16'h0;
    point_y       = 16'h0;
  end

  // Between samples the lines carry the inverse, so stale data never passes for fresh.
  task automatic send(input logic [1:0] i, input logic p, input logic [15:0] x,
                      input logic [15:0] y);
    @(posedge pclk);
    point_valid   <= 1'b1;
    point_index   <= i;
    point_present <= p;
    point_x       <= x;
    point_y       <= y;
    @(posedge pclk);
    point_valid   <= 1'b0;
    point_index   <= ~i;
    point_present <= ~p;
    point_x       <= ~x;
    point_y       <= ~y;
  endtask : send
endmodule : touch_panel_model

`default_nettype wire

//--- tb/capacitive_touch_point_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Register-level bench
// ----------------------------------------------------------------------------
module capacitive_touch_point_regs_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sampling_enable, extended_mode;
  logic point_valid, point_present;
  logic [1:0]  point_index;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] point_x, point_y;
  int          num_errors, compares;
  // Sampling, detection, then points one to four.
  logic [11:0] offs [6] = '{12'h104, 12'h108, 12'h124, 12'h11c, 12'h18c, 12'h190};
  logic [31:0] rst  [6] = '{32'h3, 32'h1, 32'h80008000, 32'h80008000, 32'h80008000,
                            32'h80008000};

  capacitive_touch_point_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .point_valid, .point_index, .point_present,
    .point_x, .point_y, .sampling_enable, .extended_mode);
  touch_panel_model tp (.pclk, .point_valid, .point_index, .point_present, .point_x, .point_y);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until pready is sampled high at a rising edge, for at most 20 edges, takes the
  // answer at that edge and only then releases the bus.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) num_errors++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    check({31'h0, e}, {31'h0, xe});
  endtask : wr

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Whole run is a few hundred cycles; this cuts a hung handshake short.
  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    compares   = 0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(offs[i], rst[i], 1'b0);
    check({31'h0, sampling_enable}, 32'h1);
    check({31'h0, extended_mode}, 32'h0);
    rd(12'h120, 32'h0, 1'b1);
    wr(12'h120, 32'hffffffff, 1'b1);
    for (int i = 2; i < 6; i++) wr(offs[i], 32'h12345678, 1'b0);
    for (int i = 2; i < 6; i++) rd(offs[i], 32'h80008000, 1'b0);
    $display("reset values and access kinds done");
    tp.send(2'h0, 1'b1, 16'h0123, 16'h0456);
    tp.send(2'h1, 1'b1, 16'h0aaa, 16'h0bbb);
    repeat (3) @(posedge pclk);
    rd(offs[2], 32'h01230456, 1'b0);
    rd(offs[3], 32'h80008000, 1'b0);
    $display("compatibility mode done");
    wr(offs[1], 32'hfffffffe, 1'b0);
    rd(offs[1], 32'h0, 1'b0);
    check({31'h0, extended_mode}, 32'h1);
    for (int i = 0; i < 4; i++) tp.send(2'(i), 1'b1, {14'h0a00, 2'(i)}, {14'h0b00, 2'(i)});
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(offs[2 + i], {14'h0a00, 2'(i), 14'h0b00, 2'(i)}, 1'b0);
    tp.send(2'h2, 1'b0, 16'h1234, 16'h5678);
    repeat (3) @(posedge pclk);
    rd(offs[4], 32'h80008000, 1'b0);
    $display("extended mode done");
    for (int m = 0; m < 4; m++)
    begin
      wr(offs[0], 32'(m), 1'b0);
      rd(offs[0], 32'(m), 1'b0);
      check({31'h0, sampling_enable}, {31'h0, m == 3});
      tp.send(2'h0, 1'b1, 16'(m), 16'h7777);
      repeat (3) @(posedge pclk);
      rd(offs[2], m == 3 ? 32'h00037777 : 32'h28002c00, 1'b0);
    end
    $display("sampling modes done");
    wr(offs[1], 32'h1, 1'b0);
    repeat (5) @(posedge pclk);
    check({31'h0, extended_mode}, 32'h0);
    rd(offs[2], 32'h00037777, 1'b0);
    for (int i = 3; i < 6; i++) rd(offs[i], 32'h80008000, 1'b0);
    $display("leaving extended mode done");
    report_and_stop();
  end
endmodule : capacitive_touch_point_regs_bench

`default_nettype wire
